// file: logic/dyn_fan_start_top.sv
// Purpose: AHB-Lite register file and two dynamic fan start temperature zones
// Assumes: temperatures and monitor_tick are synchronous to hclk
// Notes: zero wait state slave; every response is OKAY
// Functional notes
// R1: below low limit sets status flag
// R2: above high limit sets status flag
// R3: fan runs at fan start temperature
// R4: loop adjusts only fan start temperature
// R5: above critical limit drive full duty
// R6: slope setting sets duty per degree
// R7: zone too cool raises start temperature
// R8: target exceeded lowers start temperature
// R9: two independent 8-bit zone targets
// R10: targets reset to 0xa4
// R11: lowering begins above target minus hysteresis
// R12: hysteresis in bits 7:4, reset 0x40
// R13: software sets basic loop first
// R14: short cycle every n, long every 2n
// R15: lower two degrees per degree rise
// R16: above target lower one per long cycle
// R17: raise only when all four conditions hold
// R18: start temperature never wraps
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
module dyn_fan_start_top
    import dyn_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [9:0] temp_a,
    input wire logic [9:0] temp_b,
    input wire logic monitor_tick,
    output logic [7:0] fan_duty_a,
    output logic [7:0] fan_duty_b,
    output logic fan_on_a,
    output logic fan_on_b,
    output logic full_speed,
    output logic irq
);
    typedef struct packed {
        logic [7:0] target_a;
        logic [7:0] target_b;
        logic [7:0] hyst;
        logic [31:0] limits_a;
        logic [31:0] limits_b;
        logic [31:0] cfg;
        logic [NUM_EVENTS-1:0] status;
        logic [NUM_EVENTS-1:0] mask;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
    } top_s;

    top_s st;
    top_s next_st;
    logic take;
    logic [7:0] a_idx;
    logic [NUM_EVENTS-1:0] events;

    zone_if za ();
    zone_if zb ();

    // address phase is accepted only on a valid NONSEQ or SEQ transfer
    assign take = hsel && hready && htrans[1];
    assign a_idx = haddr[9:2];
    assign events = {zb.high_evt, zb.low_evt, za.high_evt, za.low_evt};

    // settings fanned out to the zone loops
    assign za.temp = temp_a;
    assign za.tick = monitor_tick;
    assign za.enable = st.cfg[ENABLE_BIT];
    assign za.target = st.target_a; // R9
    assign za.hyst = st.hyst[HYST_LSB +: 4]; // R12
    assign za.low = st.limits_a[LOW_LSB +: 8];
    assign za.high = st.limits_a[HIGH_LSB +: 8];
    assign za.crit = st.limits_a[CRIT_LSB +: 8];
    assign za.min_duty = st.limits_a[MIN_DUTY_LSB +: 8];
    assign za.code = st.cfg[CODE_A_LSB +: 3];
    assign za.slope = st.cfg[SLOPE_A_LSB +: 2];
    assign za.start_we = st.wr_pend && st.wr_idx == IDX_START_A;
    assign za.start_wdata = hwdata[7:0];
    assign zb.temp = temp_b;
    assign zb.tick = monitor_tick;
    assign zb.enable = st.cfg[ENABLE_BIT];
    assign zb.target = st.target_b; // R9
    assign zb.hyst = st.hyst[HYST_LSB +: 4]; // R12
    assign zb.low = st.limits_b[LOW_LSB +: 8];
    assign zb.high = st.limits_b[HIGH_LSB +: 8];
    assign zb.crit = st.limits_b[CRIT_LSB +: 8];
    assign zb.min_duty = st.limits_b[MIN_DUTY_LSB +: 8];
    assign zb.code = st.cfg[CODE_B_LSB +: 3];
    assign zb.slope = st.cfg[SLOPE_B_LSB +: 2];
    assign zb.start_we = st.wr_pend && st.wr_idx == IDX_START_B;
    assign zb.start_wdata = hwdata[7:0];

    dyn_zone_loop u_zone_a (
        .hclk(hclk),
        .hresetn(hresetn),
        .z(za.loop)
    );

    dyn_zone_loop u_zone_b (
        .hclk(hclk),
        .hresetn(hresetn),
        .z(zb.loop)
    );

    // bus decode, register writes and sticky status
    always_comb begin
        logic [NUM_EVENTS-1:0] clr;
        clr = '0;
        next_st = st;
        next_st.wr_pend = take && hwrite;
        if (take) begin
            next_st.wr_idx = a_idx;
        end
        // read data is captured in the address phase so it comes from flops
        if (take && !hwrite) begin
            case (a_idx)
                IDX_TARGET_A: next_st.rdata = {24'h0, st.target_a};
                IDX_TARGET_B: next_st.rdata = {24'h0, st.target_b};
                IDX_HYST: next_st.rdata = {24'h0, st.hyst};
                IDX_LIMITS_A: next_st.rdata = st.limits_a;
                IDX_LIMITS_B: next_st.rdata = st.limits_b;
                IDX_START_A: next_st.rdata = {24'h0, za.fan_start};
                IDX_START_B: next_st.rdata = {24'h0, zb.fan_start};
                IDX_CFG: next_st.rdata = st.cfg;
                IDX_STATUS: next_st.rdata = {28'h0, st.status};
                IDX_MASK: next_st.rdata = {28'h0, st.mask};
                default: next_st.rdata = 32'h0;
            endcase
        end
        if (st.wr_pend) begin
            case (st.wr_idx)
                IDX_TARGET_A: next_st.target_a = hwdata[7:0]; // R9
                IDX_TARGET_B: next_st.target_b = hwdata[7:0]; // R9
                IDX_HYST: next_st.hyst = {hwdata[7:4], 4'h0}; // R12
                IDX_LIMITS_A: next_st.limits_a = hwdata;
                IDX_LIMITS_B: next_st.limits_b = hwdata;
                IDX_CFG: next_st.cfg = hwdata & 32'h00010f3f;
                IDX_STATUS: clr = hwdata[NUM_EVENTS-1:0];
                IDX_MASK: next_st.mask = hwdata[NUM_EVENTS-1:0];
                default: ;
            endcase
        end
        // a new event in the clearing cycle stays set
        next_st.status = (st.status & ~clr) | events; // R1 R2
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{target_a: TARGET_RESET, target_b: TARGET_RESET, // R10
                hyst: HYST_RESET, limits_a: LIMITS_RESET, // R12
                limits_b: LIMITS_RESET, cfg: CFG_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = st.rdata;
    assign fan_duty_a = za.duty;
    assign fan_duty_b = zb.duty;
    assign fan_on_a = za.fan_on; // R3
    assign fan_on_b = zb.fan_on; // R3
    assign full_speed = za.full || zb.full; // R5
    assign irq = |(st.status & st.mask);
endmodule // dyn_fan_start_top

// file: logic/dyn_pkg.sv
// Purpose: shared constants for the dynamic fan start temperature loop
// Assumes: register index = byte address / 4 on a 32-bit bus
// Notes: temperatures are 8-bit codes; measured values carry two quarter bits
package dyn_pkg;
    // register indices
    localparam logic [7:0] IDX_TARGET_A = 8'h5a;
    localparam logic [7:0] IDX_TARGET_B = 8'h5b;
    localparam logic [7:0] IDX_HYST = 8'h64;
    localparam logic [7:0] IDX_LIMITS_A = 8'h70;
    localparam logic [7:0] IDX_LIMITS_B = 8'h71;
    localparam logic [7:0] IDX_START_A = 8'h72;
    localparam logic [7:0] IDX_START_B = 8'h73;
    localparam logic [7:0] IDX_CFG = 8'h74;
    localparam logic [7:0] IDX_STATUS = 8'h75;
    localparam logic [7:0] IDX_MASK = 8'h76;
    // reset values
    localparam logic [7:0] TARGET_RESET = 8'ha4;
    localparam logic [7:0] HYST_RESET = 8'h40;
    localparam logic [31:0] LIMITS_RESET = 32'h40a49e60;
    localparam logic [7:0] START_RESET = 8'h90;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    // field positions
    localparam int HYST_LSB = 4;
    localparam int LOW_LSB = 0;
    localparam int HIGH_LSB = 8;
    localparam int CRIT_LSB = 16;
    localparam int MIN_DUTY_LSB = 24;
    localparam int CODE_A_LSB = 0;
    localparam int CODE_B_LSB = 3;
    localparam int SLOPE_A_LSB = 8;
    localparam int SLOPE_B_LSB = 10;
    localparam int ENABLE_BIT = 16;
    localparam int ST_LOW_A = 0;
    localparam int ST_HIGH_A = 1;
    localparam int ST_LOW_B = 2;
    localparam int ST_HIGH_B = 3;
    localparam int NUM_EVENTS = 4;
    // loop timing and arithmetic
    localparam int CYCLE_W = 11;
    localparam int BASE_SHIFT = 3;
    localparam logic [10:0] RISE_DEADBAND = 11'h001;
    localparam logic [7:0] CRIT_HYST = 8'h04;
    localparam logic [1:0] SLOPE_MAX = 2'h3;
    localparam logic [7:0] FULL_DUTY = 8'hff;
    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;
endpackage

// file: logic/zone_if.sv
// Purpose: settings and results passed between the top and one zone loop
// Assumes: single clock domain
// Notes: temp is an 8.2 fixed point code
`timescale 1ns/1ns
interface zone_if;
    logic [9:0] temp;
    logic tick;
    logic enable;
    logic [7:0] target;
    logic [3:0] hyst;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] crit;
    logic [7:0] min_duty;
    logic [2:0] code;
    logic [1:0] slope;
    logic start_we;
    logic [7:0] start_wdata;
    logic [7:0] fan_start;
    logic [7:0] duty;
    logic fan_on;
    logic full;
    logic low_evt;
    logic high_evt;
    modport ctrl (output temp, tick, enable, target, hyst, low, high, crit, min_duty,
        code, slope, start_we, start_wdata,
        input fan_start, duty, fan_on, full, low_evt, high_evt);
    modport loop (input temp, tick, enable, target, hyst, low, high, crit, min_duty,
        code, slope, start_we, start_wdata,
        output fan_start, duty, fan_on, full, low_evt, high_evt);
endinterface // zone_if

// file: logic/dyn_zone_loop.sv
// Purpose: fan start temperature adjustment and fan drive for one zone
// Assumes: tick is a one-cycle pulse per monitoring cycle
// Notes: cycle counter wraps at 2048, a multiple of every long period
`timescale 1ns/1ns
module dyn_zone_loop
    import dyn_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    zone_if.loop z
);
    typedef struct packed {
        logic [7:0] fan_start;
        logic [9:0] prev_temp;
        logic [CYCLE_W-1:0] cnt;
        logic full;
        logic fan_on;
        logic [7:0] duty;
        logic low_evt;
        logic high_evt;
    } zone_s;

    zone_s st;
    zone_s next_st;

    // one monitoring cycle worth of decisions
    always_comb begin
        logic [7:0] t_int;
        logic [8:0] floor_th;
        logic [10:0] rise;
        logic [10:0] acc;
        logic [10:0] dec;
        logic [CYCLE_W-1:0] n_mask;
        logic short_hit;
        logic long_hit;
        logic [7:0] delta;
        logic [15:0] dsum;
        t_int = z.temp[9:2];
        delta = t_int - st.fan_start;
        dsum = {8'h00, z.min_duty} + ({8'h00, delta} << (SLOPE_MAX - z.slope)); // R6
        floor_th = {1'b0, z.target} - {5'h00, z.hyst};
        rise = {1'b0, z.temp} - {1'b0, st.prev_temp};
        dec = {1'b0, rise[10:1]};
        n_mask = (CYCLE_W'(1) << (BASE_SHIFT + int'(z.code))) - CYCLE_W'(1);
        short_hit = (st.cnt & n_mask) == '0; // R14
        long_hit = short_hit && !st.cnt[BASE_SHIFT + int'(z.code)]; // R14
        acc = {3'h0, st.fan_start};
        next_st = st;
        next_st.low_evt = 1'b0;
        next_st.high_evt = 1'b0;
        if (z.tick) begin
            next_st.cnt = st.cnt + CYCLE_W'(1);
            next_st.prev_temp = z.temp;
            next_st.low_evt = t_int < z.low; // R1
            next_st.high_evt = t_int > z.high; // R2
            // a fall shows as a huge unsigned rise, so rise[10] screens it out
            if (z.enable && short_hit && !floor_th[8] && {1'b0, t_int} > floor_th &&
                !rise[10] && rise > RISE_DEADBAND) begin // R11 R15 R8
                acc = (acc > dec) ? acc - dec : 11'h000; // R18
            end
            if (z.enable && long_hit) begin
                if (t_int > z.target) begin // R16
                    acc = (acc != 11'h000) ? acc - 11'h001 : 11'h000; // R18
                end else if (t_int < z.low && t_int > st.fan_start &&
                    st.fan_start < z.high && st.fan_start < z.target) begin // R17 R7
                    acc = acc + 11'h001; // never exceeds high, so no wrap R18
                end
            end
            next_st.fan_start = acc[7:0]; // R4
        end
        // software load of the start temperature wins over adjustment
        if (z.start_we) begin
            next_st.fan_start = z.start_wdata;
        end
        // critical limit with a fixed release band
        if (t_int > z.crit) begin
            next_st.full = 1'b1; // R5
        end else if ({1'b0, t_int} < ({1'b0, z.crit} - {1'b0, CRIT_HYST})) begin
            next_st.full = 1'b0;
        end
        next_st.fan_on = t_int >= st.fan_start; // R3
        // duty follows the new on and full states so the fan pins never disagree
        if (next_st.full) begin
            next_st.duty = FULL_DUTY; // R5
        end else if (next_st.fan_on) begin
            next_st.duty = (dsum[15:8] != 8'h00) ? FULL_DUTY : dsum[7:0];
        end else begin
            next_st.duty = 8'h00;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{fan_start: START_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign z.fan_start = st.fan_start;
    assign z.duty = st.duty;
    assign z.fan_on = st.fan_on || st.full;
    assign z.full = st.full;
    assign z.low_evt = st.low_evt;
    assign z.high_evt = st.high_evt;
endmodule // dyn_zone_loop

// file: bench/dyn_fan_start_sva.sv
// Purpose: port level checks of the fan start loop top
// Assumes: single clock, hready tied to hreadyout
// Notes: status and mask are internal, so irq is judged by its causes
`timescale 1ns/1ns
module dyn_fan_start_sva
    import dyn_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [9:0] temp_a,
    input wire logic [9:0] temp_b,
    input wire logic monitor_tick,
    input wire logic [7:0] fan_duty_a,
    input wire logic [7:0] fan_duty_b,
    input wire logic fan_on_a,
    input wire logic fan_on_b,
    input wire logic full_speed,
    input wire logic irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_taken;
    logic wr_taken;
    // transfer acceptance as the slave sees it
    assign rd_taken = hsel && hready && htrans[1] && !hwrite;
    assign wr_taken = hsel && hready && htrans[1] && hwrite;
    // critical entry has to reach a fan output within the drive lag
    sequence full_duty_s;
        ##[0:3] (fan_duty_a == FULL_DUTY || fan_duty_b == FULL_DUTY);
    endsequence
    ready_high_a: assert property (hreadyout == 1'b1) else $error("slave inserted a wait");
    resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("response not okay");
    rdata_hold_a: assert property (!$past(rd_taken) |-> $stable(hrdata))
        else $error("read data moved without a read");
    irq_raise_a: assert property ($rose(irq) |-> $past(monitor_tick, 2) ||
        $past(monitor_tick, 3) || $past(wr_taken, 1) || $past(wr_taken, 2) || $past(wr_taken, 3))
        else $error("irq rose without tick or write");
    irq_clear_a: assert property ($fell(irq) |-> $past(wr_taken, 1) ||
        $past(wr_taken, 2) || $past(wr_taken, 3)) else $error("sticky irq dropped by itself");
    fan_a_off_a: assert property (!fan_on_a |-> fan_duty_a == 8'h00)
        else $error("fan a driven while off");
    fan_b_off_a: assert property (!fan_on_b |-> fan_duty_b == 8'h00)
        else $error("fan b driven while off");
    full_duty_a: assert property ($rose(full_speed) |-> full_duty_s)
        else $error("critical without full duty");
endmodule // dyn_fan_start_sva
bind dyn_fan_start_top dyn_fan_start_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .temp_a, .temp_b,
    .monitor_tick, .fan_duty_a, .fan_duty_b, .fan_on_a, .fan_on_b, .full_speed, .irq);

// file: bench/thermal_zone_model.sv
// Purpose: remote diodes and monitor round of the far side
// Assumes: bench requests a round by toggling tick_go
// Notes: readings land one cycle after being set, like a finished conversion
`timescale 1ns/1ns
module thermal_zone_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [9:0] set_a,
    input wire logic [9:0] set_b,
    input wire logic tick_go,
    output logic [9:0] temp_a,
    output logic [9:0] temp_b,
    output logic monitor_tick
);
    logic go_seen;
    // toggle handshake keeps the tick a single cycle however the bench is timed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            go_seen <= 1'b0;
            monitor_tick <= 1'b0;
        end else begin
            monitor_tick <= tick_go ^ go_seen;
            go_seen <= tick_go;
        end
    end

    // readings carry no reset: the bench sets them long before release
    always_ff @(posedge hclk) begin
        temp_a <= set_a;
        temp_b <= set_b;
    end
endmodule // thermal_zone_model

// file: bench/testbench.sv
// Purpose: register, loop and fan drive tests of the start temperature block
// Assumes: zero wait AHB-Lite slave, counters start at reset
// Notes: tick counts below track both zones' cycle counters from zero
`timescale 1ns/1ns
module testbench;
    import dyn_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [9:0] set_a = 10'h180;
    logic [9:0] set_b = 10'h120;
    logic tick_go = 1'b0;
    logic hreadyout, hresp, monitor_tick, fan_on_a, fan_on_b, full_speed, irq;
    logic [31:0] hrdata;
    logic [9:0] temp_a, temp_b;
    logic [7:0] fan_duty_a, fan_duty_b;
    int error_cnt = 0;
    int total_checks = 0;
    always #5 hclk = ~hclk;
    thermal_zone_model u_thermal_zone_model (.hclk, .hresetn, .set_a, .set_b, .tick_go,
        .temp_a, .temp_b, .monitor_tick);
    dyn_fan_start_top u_dyn_fan_start_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .temp_a, .temp_b,
        .monitor_tick, .fan_duty_a, .fan_duty_b, .fan_on_a, .fan_on_b, .full_speed, .irq);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // bounded wait so a stuck slave ends the run instead of hanging it
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 100) begin
                error_cnt++;
                $display("Error at %0t: bus wait timed out", $time);
                end_sim;
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready;
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        chk(rd, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge hclk);
            tick_go <= ~tick_go;
            repeat (4) @(posedge hclk);
        end
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(IDX_TARGET_A, 32'ha4);
        rd_chk(IDX_TARGET_B, 32'ha4);
        rd_chk(IDX_HYST, 32'h40);
        rd_chk(IDX_LIMITS_A, LIMITS_RESET);
        rd_chk(IDX_START_A, 32'h90);
        rd_chk(8'h10, 32'h0);
        wr(IDX_TARGET_A, 32'h50);
        wr(IDX_TARGET_B, 32'h60);
        wr(IDX_HYST, 32'h4f);
        rd_chk(IDX_TARGET_A, 32'h50);
        rd_chk(IDX_TARGET_B, 32'h60);
        rd_chk(IDX_HYST, 32'h40);
        $display("test registers done");
        // basic loop settings go in before the adjustment is enabled
        wr(IDX_LIMITS_B, 32'h40907050);
        wr(IDX_START_B, 32'h40);
        wr(IDX_CFG, 32'h00010000);
        tick(1);
        rd_chk(IDX_START_A, 32'h0);
        wr(IDX_START_A, 32'h80);
        tick(15);
        rd_chk(IDX_START_A, 32'h80);
        tick(1);
        rd_chk(IDX_START_A, 32'h7f);
        tick(7);
        set_a <= 10'h184;
        tick(1);
        rd_chk(IDX_START_A, 32'h7d);
        tick(7);
        set_a <= 10'h185;
        tick(1);
        rd_chk(IDX_START_A, 32'h7c);
        rd_chk(IDX_START_B, 32'h43);
        $display("test loop done");
        rd_chk(IDX_STATUS, 32'h4);
        wr(IDX_MASK, 32'h4);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_STATUS, 32'h4);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(IDX_STATUS, 32'h0);
        $display("test interrupt done");
        set_a <= 10'h180;
        wr(IDX_START_A, 32'h5e);
        repeat (4) @(posedge hclk);
        chk({31'h0, fan_on_a}, 32'h1);
        chk({24'h0, fan_duty_a}, 32'h50);
        chk({24'h0, fan_duty_b}, 32'h68);
        chk({31'h0, fan_on_b}, 32'h1);
        wr(IDX_CFG, 32'h00010300);
        repeat (4) @(posedge hclk);
        chk({24'h0, fan_duty_a}, 32'h42);
        set_a <= 10'h2a0;
        wr(IDX_MASK, 32'h2);
        repeat (4) @(posedge hclk);
        chk({31'h0, full_speed}, 32'h1);
        chk({24'h0, fan_duty_a}, 32'hff);
        tick(1);
        rd_chk(IDX_STATUS, 32'h6);
        chk({31'h0, irq}, 32'h1);
        set_a <= 10'h180;
        repeat (4) @(posedge hclk);
        chk({31'h0, full_speed}, 32'h0);
        $display("test fan drive done");
        end_sim;
    end
endmodule // testbench
